/* File: design/esf_pkg.sv */
/*
 * Shared constants and types of the STM-1 electrical section framer:
 * timing figures, framing pattern, APB register map, status layout.
 * Assumes a 250 MHz core clock; the line side is sampled, not clocked.
 */
package esf_pkg;

    // Core clock and documented times
    localparam int CLK_MHZ = 250;
    localparam int LINE_KBPS = 155520;
    localparam int T_FRAME_US = 125;
    localparam int T_LOF_US = 3000;
    localparam int T_AIS_US = 250;
    localparam int T_LOS_NS = 1000;
    localparam int FRAME_BITS = LINE_KBPS * T_FRAME_US / 1000;
    localparam int LOF_CYCLES = T_LOF_US * CLK_MHZ;
    localparam int LOS_CYCLES = T_LOS_NS * CLK_MHZ / 1000;
    // Local client clock used while the line is gone: half period in cycles
    localparam int SUB_CLK_HALF = 4;

    // Framing: last A1 byte followed by first A2 byte
    localparam int PATTERN_BITS = 16;
    localparam logic [15:0] FRAME_PATTERN = 16'hf628;
    localparam logic [2:0] MISS_LIMIT = 3'h4;

    // APB map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_OFS_COUNT = 8'h08;
    localparam int CTRL_MONITOR_BIT = 0;
    localparam logic CTRL_MONITOR_RESET = 1'b1;
    localparam int OFS_COUNT_W = 16;

    // Synchroniser lanes
    localparam int SYNC_W = 4;
    localparam int SY_RX_CLK = 0;
    localparam int SY_RX_LINE = 1;
    localparam int SY_TX_CLK = 2;
    localparam int SY_TX_DATA = 3;

    typedef enum logic {
        ST_OUT_OF_FRAME,
        ST_IN_FRAME
    } esf_align_state_t;

    typedef struct packed {
        logic out_of_frame_second;
        logic frame_loss_cause;
        logic signal_loss_cause;
        logic server_fail_action;
        logic frame_loss_defect;
        logic out_of_frame_state;
        logic signal_loss_defect;
    } esf_status_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } esf_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } esf_apb_rsp_t;

endpackage

/* File: design/esf_framer.sv */
/*
 * STM-1 electrical section framer: CMI encoder toward the line, and on the
 * receive side loss-of-signal, CMI decoding, clock and frame recovery,
 * frame alignment, loss-of-frame integration, AIS and out-of-frame seconds.
 * Assumes line and client clocks far slower than the core clock (at least
 * four core cycles per half bit) and an APB master on the core clock.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Bitstream carries frame word every 125 us
// - Transmit path CMI-encodes client data per client clock
// - Loss of signal drives fail; cause gated by monitoring
// - Port mode selects whether defects are monitored; the code gates only the signal-loss cause, never frame loss
// - Recover bit clock and frame start for client
// - CMI-decode line before frame alignment
// - Clock recovery tracks any rate within tolerance
// - Search frame using A1/A2 subset pattern
// - Check framing in frame; OUT_OF_FRAME_STATE within 625 us
// - Four misses needed, tolerating 1e-3 errors
// - Regain frame within 250 us when clean
// - Two spaced matches required to avoid false lock
// - Frame start timing held during out-of-frame
// - Loss of frame after 3 ms integrated OUT_OF_FRAME_STATE
// - Integrator cleared only after 3 ms in frame
// - Loss of frame cleared after 3 ms in frame
// - Fail or loss of frame forces all-ones, server fail
// - Normal data resumes promptly when AIS clears
// - Each second with an OUT_OF_FRAME_STATE event is flagged
module esf_framer #(
    parameter int FRAME_BITS_P = esf_pkg::FRAME_BITS,
    parameter int LOF_CYCLES_P = esf_pkg::LOF_CYCLES,
    parameter int LOS_CYCLES_P = esf_pkg::LOS_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [esf_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Transmit client side and line
    input wire logic i_tx_client_clock,
    input wire logic i_tx_client_data,
    output logic o_line_tx,
    // Receive line
    input wire logic i_line_rx_clock,
    input wire logic i_line_rx,
    // Receive client side
    output logic o_client_data,
    output logic o_client_bit_clock,
    output logic o_client_frame_start,
    output logic o_client_server_fail,
    // Management
    input wire logic i_one_second_tick,
    output logic o_signal_loss_cause,
    output logic o_frame_loss_cause,
    output logic o_out_of_frame_second
);
    import esf_pkg::*;

    localparam int FW = $clog2(FRAME_BITS_P);
    localparam int LW = $clog2(LOF_CYCLES_P + 1);
    localparam int SW = $clog2(LOS_CYCLES_P + 1);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_BITS_P - 1);
    localparam logic [LW-1:0] LOF_LIMIT = LW'(LOF_CYCLES_P);
    localparam logic [SW-1:0] LOS_LIMIT = SW'(LOS_CYCLES_P);
    localparam logic [2:0] SUB_LAST = 3'(SUB_CLK_HALF - 1);

    // Two-stage synchronisers, plus a third stage for edge finding
    logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
    wire [SYNC_W-1:0] async_in = {i_tx_client_data, i_tx_client_clock, i_line_rx, i_line_rx_clock};

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Edges; the third stage holds the level just before each edge
    wire rx_rise = sync2_q[SY_RX_CLK] & ~sync3_q[SY_RX_CLK];
    wire rx_fall = ~sync2_q[SY_RX_CLK] & sync3_q[SY_RX_CLK];
    wire tx_rise = sync2_q[SY_TX_CLK] & ~sync3_q[SY_TX_CLK];
    wire tx_fall = ~sync2_q[SY_TX_CLK] & sync3_q[SY_TX_CLK];
    wire line_edge = sync2_q[SY_RX_LINE] ^ sync3_q[SY_RX_LINE];

    // CMI encoder: one -> alternating full-bit level, zero -> low then high
    logic tx_bit_q, tx_alt_q, line_tx_q;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_bit_q <= 1'b0;
            tx_alt_q <= 1'b0;
            line_tx_q <= 1'b0;
        end else if (tx_rise) begin
            tx_bit_q <= sync3_q[SY_TX_DATA];
            tx_alt_q <= tx_alt_q ^ sync3_q[SY_TX_DATA];
            line_tx_q <= sync3_q[SY_TX_DATA] & tx_alt_q;
        end else if (tx_fall) begin
            line_tx_q <= tx_bit_q ? line_tx_q : 1'b1;
        end
    end

    // Loss of signal: no line transition for the idle time
    logic [SW-1:0] idle_cnt_q;
    wire signal_loss_defect = (idle_cnt_q == LOS_LIMIT);
    wire incoming_trail_fail = signal_loss_defect;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            idle_cnt_q <= '0;
        end else if (line_edge) begin
            idle_cnt_q <= '0;
        end else if (!signal_loss_defect) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    // CMI decoder: halves equal is a one, differing halves a zero.
    // Purely edge driven, so any line rate in tolerance is followed.
    logic half1_q;
    wire bit_stb = rx_rise;
    wire rx_bit = (half1_q == sync3_q[SY_RX_LINE]);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            half1_q <= 1'b0;
        end else if (rx_fall) begin
            half1_q <= sync3_q[SY_RX_LINE];
        end
    end

    // Frame aligner state
    esf_align_state_t state_q, state_d;
    logic [PATTERN_BITS-2:0] shift_q;
    logic [FW-1:0] fs_cnt_q, fs_cnt_d, hunt_cnt_q, hunt_cnt_d;
    logic armed_q, armed_d;
    logic [2:0] miss_q, miss_d;

    // Pattern compare includes the bit arriving now
    wire pattern_hit = ({shift_q, rx_bit} == FRAME_PATTERN);
    wire fs_last = (fs_cnt_q == FRAME_LAST);
    wire hunt_last = (hunt_cnt_q == FRAME_LAST);
    wire [FW-1:0] fs_next = fs_last ? '0 : fs_cnt_q + 1'b1;
    wire [FW-1:0] hunt_next = hunt_last ? '0 : hunt_cnt_q + 1'b1;

    // Alignment decisions, once per received bit
    always_comb begin
        state_d = state_q;
        fs_cnt_d = fs_cnt_q;
        hunt_cnt_d = hunt_cnt_q;
        armed_d = armed_q;
        miss_d = miss_q;
        if (bit_stb) begin
            fs_cnt_d = fs_next; // free-runs, old timing kept
            case (state_q)
                ST_OUT_OF_FRAME: begin
                    hunt_cnt_d = hunt_next;
                    if (pattern_hit && armed_q && hunt_last) begin
                        // Second hit one frame later: lock
                        state_d = ST_IN_FRAME;
                        fs_cnt_d = '0;
                        miss_d = '0;
                        armed_d = 1'b0;
                    end else if (pattern_hit) begin
                        armed_d = 1'b1;
                        hunt_cnt_d = '0;
                    end else if (hunt_last) begin
                        armed_d = 1'b0;
                    end
                end
                ST_IN_FRAME: begin
                    if (fs_last) begin
                        if (pattern_hit) begin
                            miss_d = '0;
                        end else if (miss_q == MISS_LIMIT - 3'h1) begin
                            state_d = ST_OUT_OF_FRAME;
                            armed_d = 1'b0;
                            hunt_cnt_d = '0;
                        end else begin
                            miss_d = miss_q + 3'h1;
                        end
                    end
                end
                default: begin
                    state_d = ST_OUT_OF_FRAME;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_OUT_OF_FRAME;
            shift_q <= '0;
            fs_cnt_q <= '0;
            hunt_cnt_q <= '0;
            armed_q <= 1'b0;
            miss_q <= '0;
        end else begin
            state_q <= state_d;
            shift_q <= bit_stb ? {shift_q[PATTERN_BITS-3:0], rx_bit} : shift_q;
            fs_cnt_q <= fs_cnt_d;
            hunt_cnt_q <= hunt_cnt_d;
            armed_q <= armed_d;
            miss_q <= miss_d;
        end
    end

    wire out_of_frame_state = (state_q == ST_OUT_OF_FRAME);
    wire oof_event = (state_q == ST_IN_FRAME) && (state_d == ST_OUT_OF_FRAME);

    // Loss-of-frame integrator: OUT_OF_FRAME_STATE time accumulates across short returns
    // to frame, and is dropped only after a full unbroken in-frame spell.
    logic [LW-1:0] oof_acc_q, if_run_q;
    logic frame_loss_defect_q;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            oof_acc_q <= '0;
            if_run_q <= '0;
            frame_loss_defect_q <= 1'b0;
        end else if (out_of_frame_state) begin
            if_run_q <= '0;
            if (oof_acc_q == LOF_LIMIT) begin
                frame_loss_defect_q <= 1'b1;
            end else begin
                oof_acc_q <= oof_acc_q + 1'b1;
            end
        end else if (if_run_q == LOF_LIMIT) begin
            oof_acc_q <= '0;
            frame_loss_defect_q <= 1'b0;
        end else begin
            if_run_q <= if_run_q + 1'b1;
        end
    end

    // Consequent actions and causes
    logic ctrl_monitor_q;
    wire ais_insert_action = frame_loss_defect_q | incoming_trail_fail;
    wire server_fail_action = ais_insert_action;
    wire monitored_state = ctrl_monitor_q;
    wire signal_loss_cause = monitored_state & signal_loss_defect;
    wire frame_loss_cause = frame_loss_defect_q & ~incoming_trail_fail;

    // Local divider keeps the client clock running while the line is gone
    logic [2:0] sub_cnt_q;
    logic sub_clk_q;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sub_cnt_q <= '0;
            sub_clk_q <= 1'b0;
        end else if (sub_cnt_q == SUB_LAST) begin
            sub_cnt_q <= '0;
            sub_clk_q <= ~sub_clk_q;
        end else begin
            sub_cnt_q <= sub_cnt_q + 3'h1;
        end
    end

    // Client outputs; AIS takes effect on the next cycle, far inside 250 us
    logic client_data_q, client_clock_q, client_fs_q, client_ssf_q;
    wire client_data_d = ais_insert_action ? 1'b1 : (bit_stb ? rx_bit : client_data_q);
    wire client_clock_d = incoming_trail_fail ? sub_clk_q : sync2_q[SY_RX_CLK];

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            client_data_q <= 1'b1;
            client_clock_q <= 1'b0;
            client_fs_q <= 1'b0;
            client_ssf_q <= 1'b1;
        end else begin
            client_data_q <= client_data_d;
            client_clock_q <= client_clock_d;
            client_fs_q <= bit_stb && (fs_cnt_d == '0) && !incoming_trail_fail;
            client_ssf_q <= server_fail_action;
        end
    end

    // Out-of-frame seconds: an event in the tick cycle counts for this one
    logic oof_seen_q, ofs_q;
    logic [OFS_COUNT_W-1:0] ofs_count_q;
    logic ofs_count_clr;
    wire second_flagged = oof_seen_q | oof_event;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            oof_seen_q <= 1'b0;
            ofs_q <= 1'b0;
            ofs_count_q <= '0;
        end else begin
            if (i_one_second_tick) begin
                oof_seen_q <= 1'b0;
                ofs_q <= second_flagged;
            end else if (oof_event) begin
                oof_seen_q <= 1'b1;
            end
            // A clear in the same cycle as a count leaves the count at one
            if (i_one_second_tick && second_flagged) begin
                ofs_count_q <= ofs_count_clr ? OFS_COUNT_W'(1) : ofs_count_q + 1'b1;
            end else if (ofs_count_clr) begin
                ofs_count_q <= '0;
            end
        end
    end

    // Management level outputs
    logic los_cause_q, lof_cause_q;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            los_cause_q <= 1'b0;
            lof_cause_q <= 1'b0;
        end else begin
            los_cause_q <= signal_loss_cause;
            lof_cause_q <= frame_loss_cause;
        end
    end

    // APB decode; no wait state, answer registered in the setup cycle
    esf_status_t status;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    wire apb_setup = i_psel & ~i_penable;
    wire apb_done = i_psel & i_penable & pready_q;
    wire hit_ctrl = (i_paddr == REG_CTRL);
    wire hit_status = (i_paddr == REG_STATUS);
    wire hit_ofs = (i_paddr == REG_OFS_COUNT);
    wire hit_any = hit_ctrl | hit_status | hit_ofs;
    wire wr_ctrl = apb_done & i_pwrite & hit_ctrl;
    assign ofs_count_clr = apb_done & i_pwrite & hit_ofs;

    assign status.out_of_frame_second = ofs_q;
    assign status.frame_loss_cause = frame_loss_cause;
    assign status.signal_loss_cause = signal_loss_cause;
    assign status.server_fail_action = server_fail_action;
    assign status.frame_loss_defect = frame_loss_defect_q;
    assign status.out_of_frame_state = out_of_frame_state;
    assign status.signal_loss_defect = signal_loss_defect;

    // Read mux
    wire [31:0] rdata_mux = hit_ctrl ? {31'h0, ctrl_monitor_q} :
                            hit_status ? {25'h0, status} :
                            hit_ofs ? {16'h0, ofs_count_q} : 32'h0;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_monitor_q <= CTRL_MONITOR_RESET;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup & ~hit_any;
            if (apb_setup) begin
                prdata_q <= i_pwrite ? 32'h0 : rdata_mux;
            end
            if (wr_ctrl) begin
                ctrl_monitor_q <= i_pwdata[CTRL_MONITOR_BIT];
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_line_tx = line_tx_q;
    assign o_client_data = client_data_q;
    assign o_client_bit_clock = client_clock_q;
    assign o_client_frame_start = client_fs_q;
    assign o_client_server_fail = client_ssf_q;
    assign o_signal_loss_cause = los_cause_q;
    assign o_frame_loss_cause = lof_cause_q;
    assign o_out_of_frame_second = ofs_q;

endmodule

/* File: verification/esf_framer_props.sv */
/*
 * Port checker of the section framer: bus answer, defect correlation,
 * AIS, frame start and the second flag.
 * Assumes it is bound into esf_framer on the core clock.
 */
`timescale 1ns/1ps
module esf_framer_props #(
    parameter int FRAME_BITS_P = 64,
    parameter int LOF_CYCLES_P = 2000,
    parameter int LOS_CYCLES_P = 64
) (
    // Clock, reset and bus
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Client and management side
    input wire logic o_client_data,
    input wire logic o_client_bit_clock,
    input wire logic o_client_frame_start,
    input wire logic o_client_server_fail,
    input wire logic i_one_second_tick,
    input wire logic o_signal_loss_cause,
    input wire logic o_frame_loss_cause,
    input wire logic o_out_of_frame_second
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    // Bus: answer one cycle after setup, error only with zero data
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_error_zero_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error without ready or with data");
    // Causes feed server fail; loss of signal hides frame loss
    a_los_gives_fail: assert property (
        o_signal_loss_cause |-> ##[0:2] o_client_server_fail)
        else $error("signal loss without server fail");
    a_lof_gives_fail: assert property (
        o_frame_loss_cause |-> ##[0:2] o_client_server_fail)
        else $error("frame loss without server fail");
    a_causes_apart: assert property (!(o_frame_loss_cause && o_signal_loss_cause))
        else $error("both loss causes at once");
    // Two cycles of grace: data and server fail are registered in the same cycle
    a_ais_all_ones: assert property (o_client_server_fail [*3] |-> o_client_data)
        else $error("data not all ones under server fail");
    a_start_single: assert property (o_client_frame_start |=> !o_client_frame_start)
        else $error("frame start longer than one cycle");
    a_start_on_clock: assert property (
        o_client_frame_start |-> $rose(o_client_bit_clock))
        else $error("frame start off the bit clock");
    a_second_on_tick: assert property (
        !$stable(o_out_of_frame_second) |-> $past(i_one_second_tick))
        else $error("second flag moved without tick");
endmodule

bind esf_framer esf_framer_props #(.FRAME_BITS_P(FRAME_BITS_P), .LOF_CYCLES_P(LOF_CYCLES_P),
    .LOS_CYCLES_P(LOS_CYCLES_P)) u_props (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_client_data(o_client_data), .o_client_bit_clock(o_client_bit_clock),
    .o_client_frame_start(o_client_frame_start), .o_client_server_fail(o_client_server_fail),
    .i_one_second_tick(i_one_second_tick), .o_signal_loss_cause(o_signal_loss_cause),
    .o_frame_loss_cause(o_frame_loss_cause), .o_out_of_frame_second(o_out_of_frame_second));

/* File: verification/esf_line_peer.sv */
/*
 * Line peer: sends CMI-coded frames, unframed noise or nothing.
 * Assumes a 32 ns line clock that stands still while silent.
 */
`timescale 1ns/1ps
module esf_line_peer #(
    parameter int FB = 64
) (
    // Mode: 0 framed, 1 noise, 2 silent
    input wire logic [1:0] i_mode,
    // Line toward the framer
    output logic o_line_clk,
    output logic o_line
);
    import esf_pkg::*;
    int idx = 0;
    logic alt = 1'b0;
    logic b = 1'b0;
    logic [31:0] rnd = 32'h3a1;
    // Bit count runs on while silent, so the frame phase never moves
    initial begin
        o_line_clk = 1'b0;
        o_line = 1'b0;
        #3;
        forever begin
            rnd = rnd ^ (rnd << 13);
            rnd = rnd ^ (rnd >> 17);
            rnd = rnd ^ (rnd << 5);
            b = (idx < FB - 16) ? idx[0] : FRAME_PATTERN[FB - 1 - idx];
            if (i_mode == 2'd1) begin
                b = rnd[0];
            end
            idx = (idx + 1) % FB;
            if (i_mode == 2'd2) begin
                o_line_clk = 1'b0;
                o_line = 1'b0;
                #32;
            end else begin
                o_line_clk = 1'b1;
                o_line = b ? alt : 1'b0;
                #16;
                o_line_clk = 1'b0;
                o_line = b ? alt : 1'b1;
                alt = alt ^ b;
                #16;
            end
        end
    end
endmodule

/* File: verification/test_stm1_electrical_section_framer.sv */
/*
 * Bench of the section framer: bus, transmit coding, alignment,
 * loss of frame and signal, AIS and the second flag.
 * Assumes the line peer model and the bound checker.
 */
`timescale 1ns/1ps
module test_stm1_electrical_section_framer;
    import esf_pkg::*;
    localparam int FB = 64;
    localparam int LOF = 2000;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    esf_apb_req_t req = '0;
    logic txc = 1'b0, txd = 1'b0, tick = 1'b0, alt = 1'b0;
    logic cur = 1'b0, want = 1'b0, armed = 1'b0, fs_ok = 1'b0;
    logic [1:0] mode = 2'd0;
    logic [31:0] seed = 32'h75c9;
    logic [31:0] rdat;
    logic lclk, lrx, ltx, cdat, cbck, cfs, cssf, slc, flc, ofs, rdy, err;
    int tcnt = 0;
    time last_fs = 0;
    int miscompares = 0;
    int checks_done = 0;

    esf_framer #(.FRAME_BITS_P(FB), .LOF_CYCLES_P(LOF), .LOS_CYCLES_P(64)) DUT (
        .i_ref_clk(clk), .i_rstn(rstn), .i_psel(req.psel), .i_penable(req.penable),
        .i_pwrite(req.pwrite), .i_paddr(req.paddr), .i_pwdata(req.pwdata),
        .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .i_tx_client_clock(txc),
        .i_tx_client_data(txd), .o_line_tx(ltx), .i_line_rx_clock(lclk), .i_line_rx(lrx),
        .o_client_data(cdat), .o_client_bit_clock(cbck), .o_client_frame_start(cfs),
        .o_client_server_fail(cssf), .i_one_second_tick(tick), .o_signal_loss_cause(slc),
        .o_frame_loss_cause(flc), .o_out_of_frame_second(ofs));
    esf_line_peer #(.FB(FB)) u_peer (.i_mode(mode), .o_line_clk(lclk), .o_line(lrx));

    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One bus transfer; the request stands until ready is sampled
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic e);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 40);
        rd = rdat;
        e = err;
        check(32'(n < 40), 32'h1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    // Polls one status bit; n returns the cycles spent
    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        logic [31:0] d;
        logic e;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0, d, e);
            n += 3;
        end while (d[b] !== v && n < lim);
        check(32'(d[b]), 32'(v));
    endtask

    task automatic pulse_tick;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Transmit client and coder model: 8-cycle halves, data moves on fall
    always @(posedge clk) begin
        seed <= xs(seed);
        if (!rstn) begin
            tcnt <= 0;
            txc <= 1'b0;
            alt <= 1'b0;
            armed <= 1'b0;
        end else if (tcnt == 7) begin
            tcnt <= 0;
            txc <= ~txc;
            armed <= 1'b1;
            if (armed) begin
                check(32'(ltx), 32'(want));
            end
            if (!txc) begin
                want <= txd ? alt : 1'b0;
                alt <= alt ^ txd;
                cur <= txd;
            end else begin
                want <= cur ? want : 1'b1;
                txd <= seed[0];
            end
        end else begin
            tcnt <= tcnt + 1;
        end
    end

    // Frame starts keep one phase once locked; before lock the phase is free
    always @(posedge clk) begin
        if (cfs === 1'b1) begin
            if (cssf === 1'b0 && fs_ok) begin
                // Noise carries random bits, so only clean frames end in a zero
                if (mode == 2'd0) begin
                    check(32'(cdat), 32'h0);
                end
                check(32'(($time - last_fs) % (FB * 32)), 32'h0);
            end
            last_fs <= $time;
        end
    end

    initial begin
        logic [31:0] d;
        logic e;
        int n;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        // Monitor bit, unmapped place
        apb(1'b0, REG_CTRL, 32'h0, d, e);
        check(d, 32'(CTRL_MONITOR_RESET));
        apb(1'b1, REG_CTRL, 32'h0, d, e);
        apb(1'b0, REG_CTRL, 32'h0, d, e);
        check(d, 32'h0);
        apb(1'b0, 8'h3c, 32'h0, d, e);
        check({e, d[30:0]}, 32'h8000_0000);
        // Clean frames: lock, then server fail clears
        wait_bit(1, 1'b0, 4000, n);
        fs_ok <= 1'b1;
        wait_bit(3, 1'b0, 3 * LOF, n);
        // Noise: out of frame, then integrated loss of frame
        mode <= 2'd1;
        wait_bit(1, 1'b1, FB * 64, n);
        wait_bit(2, 1'b1, LOF + 300, n);
        check(32'(n >= LOF - 20 && n <= LOF + 20), 32'h1);
        check(32'({flc, slc, cssf, cdat}), 32'hb);
        pulse_tick();
        check(32'(ofs), 32'h1);
        pulse_tick();
        check(32'(ofs), 32'h0);
        apb(1'b0, REG_OFS_COUNT, 32'h0, d, e);
        check(d, 32'h1);
        apb(1'b1, REG_OFS_COUNT, 32'h0, d, e);
        apb(1'b0, REG_OFS_COUNT, 32'h0, d, e);
        check(d, 32'h0);
        // Line gone while frame loss stands, monitoring off then on
        mode <= 2'd2;
        wait_bit(0, 1'b1, 300, n);
        apb(1'b0, REG_STATUS, 32'h0, d, e);
        check(d, 32'h0f);
        apb(1'b1, REG_CTRL, 32'h1, d, e);
        apb(1'b0, REG_STATUS, 32'h0, d, e);
        check(d, 32'h1f);
        // Line back: relock, frame loss holds its full in-frame time
        mode <= 2'd0;
        wait_bit(0, 1'b0, 300, n);
        wait_bit(1, 1'b0, 4000, n);
        check(32'(flc), 32'h1);
        wait_bit(2, 1'b0, LOF + 300, n);
        check(32'(n >= LOF - 20 && n <= LOF + 20), 32'h1);
        repeat (2) @(posedge clk);
        check(32'(cssf), 32'h0);
        // Reset in mid-run; frame phase is free again until relock
        fs_ok <= 1'b0;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'({cssf, cdat, slc, flc}), 32'hc);
        rstn <= 1'b1;
        wait_bit(1, 1'b0, 4000, n);
        complete_run();
    end

    // Watchdog well beyond the expected run
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
endmodule
